// [design/adc_cfg_pkg.sv]
// constants, register map and decode helpers for the converter configuration block
package adc_cfg_pkg;
  // ==========================================================
  // bus and register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // configuration register fields
  localparam int CFG_W = 8;
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_GAIN_MSB = 3;
  localparam int CFG_PD_LSB = 4;
  localparam int CFG_PD_MSB = 6;
  localparam int CFG_CAL_BIT = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // ==========================================================
  // status register fields
  localparam int ST_W = 11;
  localparam int ST_GAIN_LSB = 0;
  localparam int ST_GAIN_MSB = 3;
  localparam int ST_LP_BIT = 4;
  localparam int ST_FAST_BIT = 5;
  localparam int ST_CONV_BIT = 6;
  localparam int ST_PIN_MODE_BIT = 7;
  localparam int ST_REF_BIT = 8;
  localparam int ST_CAL_BIT = 9;
  localparam int ST_SRST_BIT = 10;

  // ==========================================================
  // codes
  localparam logic [3:0] GAIN_SW_CTRL = 4'h0;
  localparam logic [3:0] GAIN_RESERVED = 4'hf;
  localparam logic [3:0] GAIN_RESET = 4'h1;
  localparam logic [2:0] PD_ALL_OFF = 3'h0;
  localparam logic [2:0] PD_CONV_ONLY = 3'h1;
  localparam logic [2:0] PD_FAST_ONLY = 3'h2;
  localparam logic [2:0] PD_LP_ONLY = 3'h3;
  localparam logic [2:0] PD_COMPS_ONLY = 3'h4;
  localparam logic [2:0] PD_ALL_ON = 3'h5;
  localparam logic [2:0] PD_RESET = 3'h7;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

  // ==========================================================
  // helpers
  // a gain code is usable unless it is the software-control code or reserved
  function automatic logic gain_code_valid(input logic [3:0] code);
    gain_code_valid = (code != GAIN_SW_CTRL) && (code != GAIN_RESERVED);
  endfunction

  // amplifier gain factor for a valid code, lookup table
  function automatic logic [7:0] gain_factor(input logic [3:0] code);
    case (code)
      4'h1: gain_factor = 8'h01;
      4'h2: gain_factor = 8'h02;
      4'h3: gain_factor = 8'h03;
      4'h4: gain_factor = 8'h04;
      4'h5: gain_factor = 8'h06;
      4'h6: gain_factor = 8'h08;
      4'h7: gain_factor = 8'h0c;
      4'h8: gain_factor = 8'h10;
      4'h9: gain_factor = 8'h18;
      4'ha: gain_factor = 8'h20;
      4'hb: gain_factor = 8'h30;
      4'hc: gain_factor = 8'h40;
      4'hd: gain_factor = 8'h60;
      4'he: gain_factor = 8'h80;
      default: gain_factor = 8'h01;
    endcase
  endfunction
endpackage

// [design/adc_mode_gain_powerdown_ctrl.sv]
// mode select, gain and power-down decode with axi4-lite configuration access
//
// Function
// RULE1: any gain-select pin high selects pin mode, all low selects register mode.
// RULE2: in pin mode the gain follows codes 0001..1110 as gains 1 to 128 ascending.
// RULE3: with gain pins all zero the gain comes from the configuration register.
// RULE4: in pin mode gain, power-down, reference and calibration come from the pins.
// RULE5: the power-down code comes from the register or the pins by mode.
// RULE6: power-down codes decode to the documented set of unit enables.
// RULE7: in pin mode power-down pins all low switch off every unit.
// RULE8: the controller drives 101 on the power-down pins to switch every unit on.
// RULE9: power-down code 111 acts as a reset only in pin mode.
// RULE10: that reset clears the registers and leaves every unit off.
// RULE11: after start-up in register mode units are off, gain is 1, registers clear.
// RULE12: config bits 6:4 hold the power-down code and bits 3:0 the gain code.
// RULE13: gain code 1111 is reserved and keeps the previous gain.
// RULE14: in register mode code 111 only powers down and does not clear registers.
`timescale 1ns/1ns
module adc_mode_gain_powerdown_ctrl (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [3:0] GAIN_SELECT_PINS,
  input wire logic [2:0] POWER_DOWN_CODE_PINS,
  input wire logic REFERENCE_CHOICE_PIN,
  input wire logic CAL_PIN,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic PIN_MODE,
  output logic [3:0] GAIN_CODE,
  output logic [7:0] GAIN_FACTOR,
  output logic COMP_LOW_POWER_EN,
  output logic COMP_FAST_EN,
  output logic CONV_EN,
  output logic REF_INTERNAL,
  output logic CAL_REQ,
  output logic SOFT_RESET
);
  import adc_cfg_pkg::*;
  // ==========================================================
  // pin synchronisers
  logic [3:0] gsel_meta_r, gsel_sync_r;
  logic [2:0] pd_meta_r, pd_sync_r;
  logic ref_meta_r, ref_sync_r, cal_meta_r, cal_sync_r;
  // two stages; the first stage feeds only the second
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      gsel_meta_r <= 4'h0;
      gsel_sync_r <= 4'h0;
      pd_meta_r <= 3'h0;
      pd_sync_r <= 3'h0;
      ref_meta_r <= 1'b0;
      ref_sync_r <= 1'b0;
      cal_meta_r <= 1'b0;
      cal_sync_r <= 1'b0;
    end else if (CE) begin
      gsel_meta_r <= GAIN_SELECT_PINS;
      gsel_sync_r <= gsel_meta_r;
      pd_meta_r <= POWER_DOWN_CODE_PINS;
      pd_sync_r <= pd_meta_r;
      ref_meta_r <= REFERENCE_CHOICE_PIN;
      ref_sync_r <= ref_meta_r;
      cal_meta_r <= CAL_PIN;
      cal_sync_r <= cal_meta_r;
    end
  end
  // ==========================================================
  // mode and source selection
  logic pin_mode, soft_rst;
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic [3:0] src_gain;
  logic [2:0] src_pd;
  logic src_cal;
  logic lp_en, fast_en, conv_en;
  // any gain pin high means pin mode
  assign pin_mode = |gsel_sync_r; // [RULE1]
  // all-ones code resets only when pins are in charge
  assign soft_rst = pin_mode && (pd_sync_r == PD_RESET); // [RULE9] [RULE14]
  assign src_gain = pin_mode ? gsel_sync_r : cfg_r[CFG_GAIN_MSB:CFG_GAIN_LSB]; // [RULE2] [RULE3]
  assign src_pd = pin_mode ? pd_sync_r : cfg_r[CFG_PD_MSB:CFG_PD_LSB]; // [RULE5] [RULE12]
  assign src_cal = pin_mode ? cal_sync_r : cfg_r[CFG_CAL_BIT]; // [RULE4]
  pd_decode u_pd_decode (
    .pd_code(src_pd),
    .lp_en(lp_en),
    .fast_en(fast_en),
    .conv_en(conv_en)
  );
  // ==========================================================
  // effective settings, registered so data outputs come from flops, GAIN_FACTOR through a lookup on gain_r
  logic [3:0] gain_r, gain_nxt;
  logic lp_r, lp_nxt, fast_r, fast_nxt, conv_r, conv_nxt;
  logic ref_r, cal_r, cal_nxt, srst_r, pmode_r;
  // reserved or software-control codes keep the last usable gain
  always_comb begin
    gain_nxt = gain_r; // [RULE13]
    if (soft_rst) begin
      gain_nxt = GAIN_RESET; // [RULE10]
    end else if (gain_code_valid(src_gain)) begin
      gain_nxt = src_gain; // [RULE2] [RULE4]
    end
    lp_nxt = lp_en && !soft_rst; // [RULE10]
    fast_nxt = fast_en && !soft_rst;
    conv_nxt = conv_en && !soft_rst;
    cal_nxt = src_cal && !soft_rst;
  end
  // power-on state: everything off, gain 1
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      gain_r <= GAIN_RESET; // [RULE11]
      lp_r <= 1'b0;
      fast_r <= 1'b0;
      conv_r <= 1'b0;
      ref_r <= 1'b0;
      cal_r <= 1'b0;
      srst_r <= 1'b0;
      pmode_r <= 1'b0;
    end else if (CE) begin
      gain_r <= gain_nxt;
      lp_r <= lp_nxt;
      fast_r <= fast_nxt;
      conv_r <= conv_nxt;
      ref_r <= ref_sync_r; // [RULE4]
      cal_r <= cal_nxt;
      srst_r <= soft_rst;
      pmode_r <= pin_mode;
    end
  end
  assign PIN_MODE = pmode_r;
  assign GAIN_CODE = gain_r;
  assign GAIN_FACTOR = gain_factor(gain_r);
  assign COMP_LOW_POWER_EN = lp_r;
  assign COMP_FAST_EN = fast_r;
  assign CONV_EN = conv_r;
  assign REF_INTERNAL = ref_r;
  assign CAL_REQ = cal_r;
  assign SOFT_RESET = srst_r;
  // ==========================================================
  // axi4-lite write channel
  bus_state_t wr_state_r, wr_state_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic aw_take, w_take, wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign S_AXI_AWREADY = (wr_state_r == BUS_IDLE) && !aw_got_r;
  assign S_AXI_WREADY = (wr_state_r == BUS_IDLE) && !w_got_r;
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID && S_AXI_WREADY;
  // address and data may come in either order
  assign wr_fire = (aw_got_r || aw_take) && (w_got_r || w_take);
  assign wr_addr = aw_got_r ? awaddr_r : S_AXI_AWADDR;
  assign wr_data = w_got_r ? wdata_r : S_AXI_WDATA;
  assign wr_strb = w_got_r ? wstrb_r : S_AXI_WSTRB;
  // write sequencing and configuration register update
  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = aw_take ? S_AXI_AWADDR : awaddr_r;
    wdata_nxt = w_take ? S_AXI_WDATA : wdata_r;
    wstrb_nxt = w_take ? S_AXI_WSTRB : wstrb_r;
    bresp_nxt = bresp_r;
    cfg_nxt = cfg_r;
    case (wr_state_r)
      BUS_IDLE: begin
        aw_got_nxt = aw_got_r || aw_take;
        w_got_nxt = w_got_r || w_take;
        if (wr_fire) begin
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
          wr_state_nxt = BUS_RESP;
          bresp_nxt = RESP_OKAY;
          if (wr_addr == ADDR_CONFIG) begin
            if (wr_strb[0]) begin
              cfg_nxt = wr_data[CFG_W-1:0]; // [RULE12]
            end
          end else if (wr_addr != ADDR_STATUS) begin
            bresp_nxt = RESP_SLVERR;
          end
        end
      end
      BUS_RESP: begin
        if (S_AXI_BREADY) begin
          wr_state_nxt = BUS_IDLE;
        end
      end
      default: wr_state_nxt = BUS_IDLE;
    endcase
    // pin-mode reset wins over a concurrent write
    if (soft_rst) begin
      cfg_nxt = CFG_RESET; // [RULE10]
    end
  end
  // write-side state; config starts cleared at power-on
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wr_state_r <= BUS_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
      cfg_r <= CFG_RESET; // [RULE11]
    end else if (CE) begin
      wr_state_r <= wr_state_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      cfg_r <= cfg_nxt;
    end
  end
  assign S_AXI_BVALID = (wr_state_r == BUS_RESP);
  assign S_AXI_BRESP = bresp_r;
  // ==========================================================
  // axi4-lite read channel
  bus_state_t rd_state_r, rd_state_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [ST_W-1:0] status;
  // live state snapshot for software
  always_comb begin
    status = '0;
    status[ST_GAIN_MSB:ST_GAIN_LSB] = gain_r;
    status[ST_LP_BIT] = lp_r;
    status[ST_FAST_BIT] = fast_r;
    status[ST_CONV_BIT] = conv_r;
    status[ST_PIN_MODE_BIT] = pmode_r;
    status[ST_REF_BIT] = ref_r;
    status[ST_CAL_BIT] = cal_r;
    status[ST_SRST_BIT] = srst_r;
  end
  assign S_AXI_ARREADY = (rd_state_r == BUS_IDLE);
  // read data is captured at the address handshake
  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_state_r)
      BUS_IDLE: begin
        if (S_AXI_ARVALID) begin
          rd_state_nxt = BUS_RESP;
          rresp_nxt = RESP_OKAY;
          if (S_AXI_ARADDR == ADDR_CONFIG) begin
            rdata_nxt = {{(32-CFG_W){1'b0}}, cfg_r};
          end else if (S_AXI_ARADDR == ADDR_STATUS) begin
            rdata_nxt = {{(32-ST_W){1'b0}}, status};
          end else begin
            rdata_nxt = 32'h0;
            rresp_nxt = RESP_SLVERR;
          end
        end
      end
      BUS_RESP: begin
        if (S_AXI_RREADY) begin
          rd_state_nxt = BUS_IDLE;
        end
      end
      default: rd_state_nxt = BUS_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_state_r <= BUS_IDLE;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (CE) begin
      rd_state_r <= rd_state_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign S_AXI_RVALID = (rd_state_r == BUS_RESP);
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
endmodule

// [design/pd_decode.sv]
// power-down code to unit enables
`timescale 1ns/1ns
module pd_decode (
  input wire logic [2:0] pd_code,
  output logic lp_en,
  output logic fast_en,
  output logic conv_en
);
  import adc_cfg_pkg::*;
  // ==========================================================
  // code table; 110 is undefined and treated as all off for safety
  always_comb begin
    lp_en = 1'b0;
    fast_en = 1'b0;
    conv_en = 1'b0;
    case (pd_code)
      PD_CONV_ONLY: conv_en = 1'b1; // [RULE6]
      PD_FAST_ONLY: fast_en = 1'b1; // [RULE6]
      PD_LP_ONLY: lp_en = 1'b1; // [RULE6]
      PD_COMPS_ONLY: begin
        lp_en = 1'b1; // [RULE6]
        fast_en = 1'b1;
      end
      PD_ALL_ON: begin
        lp_en = 1'b1; // [RULE6] [RULE8]
        fast_en = 1'b1;
        conv_en = 1'b1;
      end
      default: begin
        lp_en = 1'b0; // [RULE6] [RULE7]
        fast_en = 1'b0;
        conv_en = 1'b0;
      end
    endcase
  end
endmodule

// [verif/adc_cfg_monitor.sv]
// assertion checker for the configuration decode block
`timescale 1ns/1ns
module adc_cfg_monitor (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] GAIN_SELECT_PINS,
  input wire logic [2:0] POWER_DOWN_CODE_PINS,
  input wire logic PIN_MODE,
  input wire logic [3:0] GAIN_CODE,
  input wire logic [7:0] GAIN_FACTOR,
  input wire logic COMP_LOW_POWER_EN,
  input wire logic COMP_FAST_EN,
  input wire logic CONV_EN,
  input wire logic SOFT_RESET
);
  // ==========================================================
  // expected tables, enables ordered low-power, fast, converters
  localparam logic [7:0] gain_tab [16] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08,
    8'h0c, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h01};
  localparam logic [2:0] pd_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h0, 3'h0};
  logic [2:0] en;
  // one field for the three enables
  assign en = {COMP_LOW_POWER_EN, COMP_FAST_EN, CONV_EN};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // sequences and properties
  // two sync flops plus the output flop: four steady samples cover it
  sequence s_steady;
    ($stable(GAIN_SELECT_PINS) && $stable(POWER_DOWN_CODE_PINS)) [*4];
  endsequence
  sequence s_pin;
    s_steady ##0 (GAIN_SELECT_PINS != 4'h0);
  endsequence
  property p_mode;
    s_steady |-> PIN_MODE == (|GAIN_SELECT_PINS);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_gain;
    s_pin ##0 (GAIN_SELECT_PINS != 4'hf && POWER_DOWN_CODE_PINS != 3'h7)
      |-> GAIN_CODE == GAIN_SELECT_PINS;
  endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_factor;
    GAIN_FACTOR == gain_tab[GAIN_CODE];
  endproperty
  a_factor: assert property (p_factor) else $error("factor wrong");
  property p_pd;
    s_pin |-> en == pd_tab[POWER_DOWN_CODE_PINS];
  endproperty
  a_pd: assert property (p_pd) else $error("enables wrong");
  property p_srst;
    s_pin ##0 (POWER_DOWN_CODE_PINS == 3'h7) |-> SOFT_RESET && GAIN_CODE == 4'h1;
  endproperty
  a_srst: assert property (p_srst) else $error("no soft reset");
  property p_no_srst;
    (GAIN_SELECT_PINS == 4'h0) [*4] |-> !SOFT_RESET;
  endproperty
  a_no_srst: assert property (p_no_srst) else $error("stray soft reset");
  property p_rsv;
    s_pin ##0 (GAIN_SELECT_PINS == 4'hf && POWER_DOWN_CODE_PINS != 3'h7) |-> $stable(GAIN_CODE);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved gain used");
  property p_start;
    $fell(RST) |-> GAIN_CODE == 4'h1 && en == 3'h0 && !SOFT_RESET;
  endproperty
  a_start: assert property (p_start) else $error("start state wrong");
endmodule

bind adc_mode_gain_powerdown_ctrl adc_cfg_monitor mon (.REF_CLK(REF_CLK), .RST(RST),
  .GAIN_SELECT_PINS(GAIN_SELECT_PINS), .POWER_DOWN_CODE_PINS(POWER_DOWN_CODE_PINS),
  .PIN_MODE(PIN_MODE), .GAIN_CODE(GAIN_CODE), .GAIN_FACTOR(GAIN_FACTOR),
  .COMP_LOW_POWER_EN(COMP_LOW_POWER_EN), .COMP_FAST_EN(COMP_FAST_EN), .CONV_EN(CONV_EN),
  .SOFT_RESET(SOFT_RESET));

// [verif/pin_host_model.sv]
// host model driving the static configuration pins
`timescale 1ns/1ns
module pin_host_model (
  input wire logic clk,
  input wire logic [3:0] gain_set,
  input wire logic [2:0] pd_set,
  input wire logic all_on,
  input wire logic ref_set,
  input wire logic cal_set,
  output logic [3:0] gain_pins = 4'h0,
  output logic [2:0] pd_pins = 3'h0,
  output logic ref_pin = 1'b0,
  output logic cal_pin = 1'b0
);
  // ==========================================================
  // pin drivers
  // pins move just after an edge, like a controller port register
  always @(posedge clk) begin
    gain_pins <= gain_set;
    pd_pins <= all_on ? 3'h5 : pd_set;
    ref_pin <= ref_set;
    cal_pin <= cal_set;
  end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the configuration decode block
`timescale 1ns/1ns
module tb_top;
  import adc_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic all_on = 1'b0, ref_set = 1'b0, cal_set = 1'b0;
  logic [3:0] gain_set = 4'h0;
  logic [2:0] pd_set = 3'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_mode, ref_pin, cal_pin;
  logic lp, fast, conv, ref_int, cal_req, srst;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [3:0] gain_pins, gain_code;
  logic [2:0] pd_pins;
  logic [7:0] gain_factor;
  int mismatches = 0, num_checks = 0;
  logic [7:0] gain_tab [16] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c,
    8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h01};
  logic [2:0] pd_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h0, 3'h0};
  // ==========================================================
  // clock and instances
  always #25 clk = ~clk;
  pin_host_model host (.clk(clk), .gain_set(gain_set), .pd_set(pd_set), .all_on(all_on),
    .ref_set(ref_set), .cal_set(cal_set), .gain_pins(gain_pins), .pd_pins(pd_pins),
    .ref_pin(ref_pin), .cal_pin(cal_pin));
  // clock enable and byte strobes tied active
  adc_mode_gain_powerdown_ctrl DUT (.REF_CLK(clk), .RST(rst), .CE(1'b1),
    .GAIN_SELECT_PINS(gain_pins), .POWER_DOWN_CODE_PINS(pd_pins), .REFERENCE_CHOICE_PIN(ref_pin),
    .CAL_PIN(cal_pin), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_MODE(pin_mode), .GAIN_CODE(gain_code),
    .GAIN_FACTOR(gain_factor), .COMP_LOW_POWER_EN(lp), .COMP_FAST_EN(fast), .CONV_EN(conv),
    .REF_INTERNAL(ref_int), .CAL_REQ(cal_req), .SOFT_RESET(srst));
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic look(input logic [3:0] g, input logic [2:0] e);
    chk("gain_code", g, gain_code);
    chk("enables", e, {lp, fast, conv});
  endtask
  // pins need the host register plus three edges; six leaves margin
  task automatic pins(input logic [3:0] g, input logic [2:0] p);
    gain_set <= g;
    pd_set <= p;
    repeat (6) @(posedge clk);
  endtask
  // both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    look(4'h1, 3'h0);
    axi_rd(ADDR_CONFIG);
    chk("config", 32'h0, d);
    $display("done reset");
  endtask
  // code 15 is reserved, so the last valid gain must survive it
  task automatic t_gain_pins();
    all_on <= 1'b1;
    for (int c = 1; c < 16; c++) begin
      pins(c[3:0], 3'h0);
      chk("pin_mode", 1'b1, pin_mode);
      look((c == 15) ? 4'he : c[3:0], 3'h7);
      chk("gain_factor", gain_tab[(c == 15) ? 14 : c], gain_factor);
    end
    all_on <= 1'b0;
    $display("done gain pins");
  endtask
  task automatic t_pd_pins();
    ref_set <= 1'b1;
    cal_set <= 1'b1;
    for (int p = 0; p < 7; p++) begin
      pins(4'h2, p[2:0]);
      look(4'h2, pd_tab[p]);
    end
    chk("ref_internal", 1'b1, ref_int);
    chk("cal_req", 1'b1, cal_req);
    ref_set <= 1'b0;
    cal_set <= 1'b0;
    $display("done pd pins");
  endtask
  task automatic t_soft_reset();
    pins(4'h0, 3'h0);
    axi_wr(ADDR_CONFIG, 32'h5a);
    pins(4'h3, 3'h7);
    chk("soft_reset", 1'b1, srst);
    look(4'h1, 3'h0);
    pins(4'h0, 3'h0);
    axi_rd(ADDR_CONFIG);
    chk("config", 32'h0, d);
    $display("done soft reset");
  endtask
  task automatic t_reg_mode();
    for (int p = 0; p < 8; p++) begin
      axi_wr(ADDR_CONFIG, {25'h0, p[2:0], 4'h3});
      chk("bresp", RESP_OKAY, r);
      repeat (3) @(posedge clk);
      look(4'h3, pd_tab[p]);
      chk("soft_reset", 1'b0, srst);
    end
    axi_rd(ADDR_CONFIG);
    chk("config", 32'h73, d);
    // all-ones power-down pins must not reset while the register is in charge
    pins(4'h0, 3'h7);
    chk("soft_reset", 1'b0, srst);
    look(4'h3, 3'h0);
    // reserved gain code, calibration requested from the register
    axi_wr(ADDR_CONFIG, 32'hdf);
    repeat (3) @(posedge clk);
    look(4'h3, 3'h7);
    chk("cal_req", 1'b1, cal_req);
    axi_rd(ADDR_STATUS);
    chk("status", 32'h273, d);
    axi_wr(8'h0c, 32'h0);
    chk("bresp", RESP_SLVERR, r);
    axi_rd(8'h08);
    chk("rresp", RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    $display("done register mode");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence, with a second reset in mid-run
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_gain_pins();
    t_pd_pins();
    t_soft_reset();
    t_reg_mode();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    report_and_stop();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule
